// *** logic/pet_defs.svh ***
// constants for the pulse/event/capture timer
`ifndef PET_DEFS_SVH
`define PET_DEFS_SVH

`define PET_ADDR_W          6
`define PET_OFS_CTRL        6'h00
`define PET_OFS_RELOAD_A    6'h04
`define PET_OFS_RELOAD_B    6'h08
`define PET_OFS_TIMER       6'h0c
`define PET_OFS_STATUS      6'h10
`define PET_OFS_IRQ_EN      6'h14

`define PET_CTRL_UF_BIT     0
`define PET_CTRL_LO_BIT     1
`define PET_CTRL_MID_BIT    2
`define PET_CTRL_HI_BIT     3
`define PET_STAT_A_BIT      0
`define PET_STAT_B_BIT      1

`define PET_CTRL_RESET      4'h0
`define PET_STAT_RESET      2'h0
`define PET_IRQ_EN_RESET    2'h0

`define PET_CLK_DIV         10

`endif

// *** logic/pet_pkg.sv ***
// types shared by the pulse/event/capture timer
package pet_pkg;

    typedef enum logic [1:0] {
        PET_MODE_PWM,
        PET_MODE_EVENT,
        PET_MODE_CAPTURE
    } pet_mode_type;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [5:0]  address;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } pet_avm_req_type;

endpackage : pet_pkg

// *** logic/pet_timer.sv ***
// 16-bit pulse-width / event-counter / capture timer with avalon-mm registers
// Operation
// - two 16-bit reload registers, A and B
// - pwm counts per cycle, reloads A, B alternately
// - pwm toggle setting inverts pin A per underflow
// - pwm reload source sets matching pending flag
// - interrupt per flag only when its enable set
// - three mode bits select pwm, event, capture
// - event mode counts selected pin A edges
// - event mode underflow sets pending flag A
// - event mode pin B rising edge sets flag B
// - event mode never drives pin A
// - capture mode free runs, edges copy count
// - capture edge per pin selectable, sets flags
// - capture underflow sets ctrl bit 0 (the UF bit, below the mode bits), gated A
// - capture registers readable without disturbing count
// - instruction clock is oscillator divided by ten
// - timer and reload registers have no reset
//
// Decided for this implementation: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`include "pet_defs.svh"

module pet_timer #(
    parameter int CNT_W = 16
) (
    input  wire logic                 ref_clk_in,
    input  wire logic                 reset_in,
    input  wire pet_pkg::pet_avm_req_type avs_req_in,
    output logic [31:0]               avs_readdata_out,
    output logic                      avs_waitrequest_out,
    input  wire logic                 timer_pin_a_in,
    output logic                      timer_pin_a_out,
    output logic                      timer_pin_a_oe_out,
    input  wire logic                 timer_pin_b_in,
    output logic                      irq_out
);
    import pet_pkg::*;

    logic [3:0]       ctrl_reg;
    logic [1:0]       pend_reg;
    logic [1:0]       irq_en_reg;
    logic [CNT_W-1:0] main_timer_reg;
    logic [CNT_W-1:0] reload_capture_a_reg;
    logic [CNT_W-1:0] reload_capture_b_reg;
    logic [3:0]       div_reg;
    logic             tick;
    logic             pin_a_q_reg;
    logic             pin_b_q_reg;
    logic             next_from_b_reg;
    logic             pin_a_drive_reg;
    logic             pin_a_oe_reg;
    logic             irq_reg;
    logic             wait_reg;
    logic [31:0]      rdata_reg;
    pet_mode_type     mode;
    logic             toggle_sel;
    logic             edge_a;
    logic             edge_b;
    logic             count_en;
    logic             underflow;
    logic             req;
    logic             wr_fire;
    logic [CNT_W-1:0] wr_val;

    //////////////////////////////////////////////////////////////////////////
    // mode decode

    always_comb begin
        if (!ctrl_reg[`PET_CTRL_MID_BIT] && ctrl_reg[`PET_CTRL_HI_BIT]) begin
            mode = PET_MODE_PWM;
        end else if (!ctrl_reg[`PET_CTRL_MID_BIT]) begin
            mode = PET_MODE_EVENT;
        end else begin
            mode = PET_MODE_CAPTURE;
        end
    end

    // in pwm the lo mode bit picks toggle (101) or steady pin (100)
    assign toggle_sel = ctrl_reg[`PET_CTRL_LO_BIT];

    //////////////////////////////////////////////////////////////////////////
    // instruction-cycle enable

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            div_reg <= 4'h0;
        end else if (div_reg == 4'(`PET_CLK_DIV - 1)) begin
            div_reg <= 4'h0;
        end else begin
            div_reg <= div_reg + 4'h1;
        end
    end

    assign tick = (div_reg == 4'(`PET_CLK_DIV - 1));

    //////////////////////////////////////////////////////////////////////////
    // pin edge detection

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            pin_a_q_reg <= 1'b0;
            pin_b_q_reg <= 1'b0;
        end else begin
            pin_a_q_reg <= timer_pin_a_in;
            pin_b_q_reg <= timer_pin_b_in;
        end
    end

    // lo bit picks the falling edge of pin A, in event and capture modes alike
    assign edge_a = ctrl_reg[`PET_CTRL_LO_BIT] ? (pin_a_q_reg && !timer_pin_a_in)
                                               : (!pin_a_q_reg && timer_pin_a_in);
    // pin B: rising in event mode; in capture falling once hi or lo is set
    assign edge_b = (mode == PET_MODE_CAPTURE && (ctrl_reg[`PET_CTRL_LO_BIT] || ctrl_reg[`PET_CTRL_HI_BIT]))
                    ? (pin_b_q_reg && !timer_pin_b_in) : (!pin_b_q_reg && timer_pin_b_in);

    assign count_en  = (mode == PET_MODE_EVENT) ? edge_a : tick;
    assign underflow = count_en && (main_timer_reg == '0);

    //////////////////////////////////////////////////////////////////////////
    // register bus: one wait cycle, then a single-cycle acknowledge

    assign req     = avs_req_in.read || avs_req_in.write;
    assign wr_fire = avs_req_in.write && !wait_reg;
    assign wr_val  = {avs_req_in.byteenable[1] ? avs_req_in.writedata[15:8] : 8'h00,
                      avs_req_in.byteenable[0] ? avs_req_in.writedata[7:0]  : 8'h00};

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            wait_reg <= 1'b1;
        end else if (req && wait_reg) begin
            wait_reg <= 1'b0;
        end else begin
            wait_reg <= 1'b1;
        end
    end

    // read data is latched on the same edge that drops waitrequest, so it stands during the acknowledge
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            rdata_reg <= 32'h0000_0000;
        end else if (avs_req_in.read && wait_reg) begin
            if (avs_req_in.address == `PET_OFS_CTRL) begin
                rdata_reg <= {28'h0000000, ctrl_reg};
            end else if (avs_req_in.address == `PET_OFS_RELOAD_A) begin
                rdata_reg <= {16'h0000, reload_capture_a_reg};
            end else if (avs_req_in.address == `PET_OFS_RELOAD_B) begin
                rdata_reg <= {16'h0000, reload_capture_b_reg};
            end else if (avs_req_in.address == `PET_OFS_TIMER) begin
                rdata_reg <= {16'h0000, main_timer_reg};
            end else if (avs_req_in.address == `PET_OFS_STATUS) begin
                rdata_reg <= {30'h00000000, pend_reg};
            end else if (avs_req_in.address == `PET_OFS_IRQ_EN) begin
                rdata_reg <= {30'h00000000, irq_en_reg};
            end else begin
                rdata_reg <= 32'h0000_0000;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // control and enable registers

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            ctrl_reg <= `PET_CTRL_RESET;
        end else begin
            if (wr_fire && avs_req_in.address == `PET_OFS_CTRL && avs_req_in.byteenable[0]) begin
                ctrl_reg <= avs_req_in.writedata[3:0];
            end
            if (mode == PET_MODE_CAPTURE && underflow) begin
                ctrl_reg[`PET_CTRL_UF_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            irq_en_reg <= `PET_IRQ_EN_RESET;
        end else if (wr_fire && avs_req_in.address == `PET_OFS_IRQ_EN && avs_req_in.byteenable[0]) begin
            irq_en_reg <= avs_req_in.writedata[1:0];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // pending flags: write one to clear, hardware set wins

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            pend_reg <= `PET_STAT_RESET;
        end else begin
            if (wr_fire && avs_req_in.address == `PET_OFS_STATUS && avs_req_in.byteenable[0]) begin
                pend_reg <= pend_reg & ~avs_req_in.writedata[1:0];
            end
            if (mode == PET_MODE_CAPTURE) begin
                if (edge_a) begin
                    pend_reg[`PET_STAT_A_BIT] <= 1'b1;
                end
                if (edge_b) begin
                    pend_reg[`PET_STAT_B_BIT] <= 1'b1;
                end
            end else begin
                if (underflow && (!next_from_b_reg || mode == PET_MODE_EVENT)) begin
                    pend_reg[`PET_STAT_A_BIT] <= 1'b1;
                end
                if (underflow && next_from_b_reg && mode == PET_MODE_PWM) begin
                    pend_reg[`PET_STAT_B_BIT] <= 1'b1;
                end
                if (mode == PET_MODE_EVENT && edge_b) begin
                    pend_reg[`PET_STAT_B_BIT] <= 1'b1;
                end
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // counter and reload/capture registers, deliberately without reset

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            next_from_b_reg <= 1'b0;
        end else if (mode == PET_MODE_CAPTURE) begin
            next_from_b_reg <= 1'b0;
        end else if (underflow) begin
            next_from_b_reg <= !next_from_b_reg;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (underflow && mode != PET_MODE_CAPTURE) begin
            main_timer_reg <= next_from_b_reg ? reload_capture_b_reg : reload_capture_a_reg;
        end else if (count_en) begin
            main_timer_reg <= main_timer_reg - 1'b1;
        end else if (wr_fire && avs_req_in.address == `PET_OFS_TIMER) begin
            main_timer_reg <= wr_val;
        end
    end

    // a capture edge beats a colliding software write
    always_ff @(posedge ref_clk_in) begin
        if (mode == PET_MODE_CAPTURE && edge_a) begin
            reload_capture_a_reg <= main_timer_reg;
        end else if (wr_fire && avs_req_in.address == `PET_OFS_RELOAD_A) begin
            reload_capture_a_reg <= wr_val;
        end
        if (mode == PET_MODE_CAPTURE && edge_b) begin
            reload_capture_b_reg <= main_timer_reg;
        end else if (wr_fire && avs_req_in.address == `PET_OFS_RELOAD_B) begin
            reload_capture_b_reg <= wr_val;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // pin A output and interrupt

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            pin_a_drive_reg <= 1'b0;
            pin_a_oe_reg    <= 1'b0;
        end else begin
            pin_a_oe_reg <= (mode == PET_MODE_PWM);
            if (mode == PET_MODE_PWM && toggle_sel && underflow) begin
                pin_a_drive_reg <= !pin_a_drive_reg;
            end
        end
    end

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= (pend_reg[`PET_STAT_A_BIT] && irq_en_reg[0])
                    || (pend_reg[`PET_STAT_B_BIT] && irq_en_reg[1])
                    || (mode == PET_MODE_CAPTURE && ctrl_reg[`PET_CTRL_UF_BIT] && irq_en_reg[0]);
        end
    end

    assign avs_readdata_out    = rdata_reg;
    assign avs_waitrequest_out = wait_reg;
    assign timer_pin_a_out     = pin_a_drive_reg;
    assign timer_pin_a_oe_out  = pin_a_oe_reg;
    assign irq_out             = irq_reg;

    //////////////////////////////////////////////////////////////////////////
    // checks

    a_tick_period: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        tick |-> ##1 (!tick) [*8] ##1 !tick ##1 tick)
        else $error("instruction tick not every ten clocks");
    a_pwm_reload_src: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (mode == PET_MODE_PWM && underflow && !wr_fire)
        |=> main_timer_reg == ($past(next_from_b_reg) ? $past(reload_capture_b_reg) : $past(reload_capture_a_reg))
            && next_from_b_reg != $past(next_from_b_reg))
        else $error("pwm reload source or alternation wrong");
    a_pwm_toggle_pin: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (mode == PET_MODE_PWM && underflow) |=> (timer_pin_a_out != $past(timer_pin_a_out)) == $past(toggle_sel))
        else $error("pin A toggle does not follow setting");
    a_pwm_flag_set: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (mode == PET_MODE_PWM && underflow && next_from_b_reg) |=> pend_reg[`PET_STAT_B_BIT])
        else $error("flag B not set on reload from B");
    a_irq_gate: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (!irq_en_reg[0] && !irq_en_reg[1]) [*2] |-> !irq_out)
        else $error("interrupt raised while both enables clear");
    a_event_count: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (mode == PET_MODE_EVENT && !edge_a && !wr_fire) |=> $stable(main_timer_reg))
        else $error("event counter moved without a pin A edge");
    a_pinb_edge: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (mode == PET_MODE_EVENT && !pin_b_q_reg && timer_pin_b_in) |=> pend_reg[`PET_STAT_B_BIT])
        else $error("pin B rising edge not latched");

    a_event_no_drive: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (mode == PET_MODE_EVENT) [*2] |-> !timer_pin_a_oe_out)
        else $error("pin A driven in event mode");

    a_capture_copy: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (mode == PET_MODE_CAPTURE && edge_a) |=> reload_capture_a_reg == $past(main_timer_reg))
        else $error("capture A missed the count");

    a_capture_wrap: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (mode == PET_MODE_CAPTURE && underflow)
        |=> main_timer_reg == '1 && ctrl_reg[`PET_CTRL_UF_BIT])
        else $error("capture underflow did not wrap or flag");

    a_bus_answer: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (req && avs_waitrequest_out) |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
        else $error("bus answer not one cycle after request");

    c_pwm_both: cover property (@(posedge ref_clk_in) disable iff (reset_in)
        mode == PET_MODE_PWM && underflow && next_from_b_reg);
    c_event_uf: cover property (@(posedge ref_clk_in) disable iff (reset_in)
        mode == PET_MODE_EVENT && underflow);
    c_capture_ab: cover property (@(posedge ref_clk_in) disable iff (reset_in)
        mode == PET_MODE_CAPTURE && edge_a && edge_b);

endmodule : pet_timer

// *** test/pet_pin_model.sv ***
// partner model: the outside world on timer pins a and b
`timescale 1ns/1ps
module pet_pin_model (
    input  wire logic clk_in,
    input  wire logic dev_a_in,
    input  wire logic dev_oe_in,
    output logic      pin_a_out,
    output logic      pin_b_out
);
    logic drv_a;

    initial begin
        drv_a     = 1'b0;
        pin_b_out = 1'b0;
    end

    // the device owns pin a whenever it drives it
    assign pin_a_out = dev_oe_in ? dev_a_in : drv_a;

    // levels held two clocks so no edge can slip between samples
    task automatic set_pins(input logic a, input logic b);
        @(posedge clk_in);
        drv_a     <= a;
        pin_b_out <= b;
        repeat (2) @(posedge clk_in);
    endtask : set_pins
endmodule : pet_pin_model

// *** test/tb_pwm_event_capture_timer.sv ***
// self-checking bench for the pulse/event/capture timer
`timescale 1ns/1ps
`include "pet_defs.svh"
module tb_pwm_event_capture_timer;
    import pet_pkg::*;
    logic            clk;
    logic            rst;
    pet_avm_req_type req;
    logic [31:0]     rdata;
    logic            wait_req;
    logic            pa_out;
    logic            pa_oe;
    logic            pa_lvl;
    logic            pb_lvl;
    logic            irq;
    logic            pa_prev;
    logic [31:0]     v;
    logic [31:0]     t1;
    logic [31:0]     t2;
    logic [3:0]      cm [4];
    int              error_cnt;
    int              compares;
    int              cyc;
    int              seed;
    int              n;
    int              tmr;
    int              ptr;
    int              exp_st;
    int              tog_q[$];

    pet_timer dut (
        .ref_clk_in          (clk),
        .reset_in            (rst),
        .avs_req_in          (req),
        .avs_readdata_out    (rdata),
        .avs_waitrequest_out (wait_req),
        .timer_pin_a_in      (pa_lvl),
        .timer_pin_a_out     (pa_out),
        .timer_pin_a_oe_out  (pa_oe),
        .timer_pin_b_in      (pb_lvl),
        .irq_out             (irq)
    );

    pet_pin_model pins (
        .clk_in    (clk),
        .dev_a_in  (pa_out),
        .dev_oe_in (pa_oe),
        .pin_a_out (pa_lvl),
        .pin_b_out (pb_lvl)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // toggle times of the driven pin, in clocks
    always @(posedge clk) begin
        cyc     <= cyc + 1;
        pa_prev <= pa_out;
        if (pa_oe === 1'b1 && pa_out !== pa_prev)
            tog_q.push_back(cyc);
    end

    ////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic bus(input logic wr, input logic [5:0] adr, input logic [31:0] wd, output logic [31:0] rd);
        int k;
        req <= '{read: !wr, write: wr, address: adr, byteenable: 4'hf, writedata: wd};
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (wait_req !== 1'b0 && k < 50);
        rd = rdata;
        if (k >= 50)
            check(1'b1, 1'b0, "bus hang");
        req <= '0;
        @(posedge clk);
    endtask : bus

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus(1'b1, a, d, dummy);
    endtask : wr

    task automatic rd_chk(input logic [5:0] a, input logic [31:0] e, input string what);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        check(r, e, what);
    endtask : rd_chk

    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish

    // whole run is under two thousand clocks
    initial begin
        repeat (30000) @(posedge clk);
        error_cnt++;
        tally_and_finish();
    end

    ////////////////////////////////////////
    initial begin
        rst = 1'b1;
        req = '0;
        cyc = 0;
        pa_prev = 1'b0;
        error_cnt = 0;
        compares = 0;
        seed = 32'h2b61;
        cm = '{4'h4, 4'hc, 4'h6, 4'he};
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_chk(`PET_OFS_CTRL, 0, "ctrl reset");
        rd_chk(`PET_OFS_STATUS, 0, "status reset");
        rd_chk(`PET_OFS_IRQ_EN, 0, "irq enable reset");
        rd_chk(6'h18, 0, "unmapped read");
        check(pa_oe, 1'b0, "pin a idle");
        $display("test reset done");

        // event counting: model counts only edges of the chosen polarity
        ptr = 0;
        for (int pol = 0; pol < 2; pol++) begin
            tmr = 3 + ($unsigned($random(seed)) % 12);
            wr(`PET_OFS_RELOAD_A, 5);
            wr(`PET_OFS_RELOAD_B, 9);
            wr(`PET_OFS_TIMER, tmr);
            wr(`PET_OFS_CTRL, pol * 2);
            wr(`PET_OFS_STATUS, 3);
            wr(`PET_OFS_IRQ_EN, 1);
            exp_st = 0;
            n = 6 + ($unsigned($random(seed)) % 20);
            for (int i = 0; i < n; i++) begin
                if ((pa_lvl === 1'b0) == (pol == 0)) begin
                    if (tmr == 0) begin
                        tmr = ptr ? 9 : 5;
                        ptr = 1 - ptr;
                        exp_st = 1;
                    end else
                        tmr--;
                end
                pins.set_pins(~pa_lvl, 1'b0);
            end
            pins.set_pins(pa_lvl, 1'b1);
            rd_chk(`PET_OFS_TIMER, tmr, "event count");
            rd_chk(`PET_OFS_STATUS, exp_st | 2, "event flags");
            check(irq, exp_st[0], "event irq gating");
            check(pa_oe, 1'b0, "pin a not driven");
        end
        $display("test event done");

        // capture: rising then falling edge on both pins, all four settings
        wr(`PET_OFS_IRQ_EN, 3);
        for (int i = 0; i < 4; i++) begin
            pins.set_pins(1'b0, 1'b0);
            wr(`PET_OFS_TIMER, 16'h8000);
            wr(`PET_OFS_CTRL, cm[i]); // bit 0 cleared on entry
            wr(`PET_OFS_STATUS, 3);
            bus(1'b0, `PET_OFS_TIMER, 0, t1);
            pins.set_pins(1'b1, 1'b1);
            bus(1'b0, `PET_OFS_TIMER, 0, t2);
            rd_chk(`PET_OFS_STATUS, {~(cm[i][3] | cm[i][1]), ~cm[i][1]}, "rise flags");
            if (!cm[i][1]) begin
                bus(1'b0, `PET_OFS_RELOAD_A, 0, v);
                check((v <= t1) && (v >= t2) && (t2 < 16'h8001), 1'b1, "capture a value");
            end
            wr(`PET_OFS_STATUS, 3);
            pins.set_pins(1'b0, 1'b0);
            rd_chk(`PET_OFS_STATUS, {cm[i][3] | cm[i][1], cm[i][1]}, "fall flags");
            check(irq, cm[i][3] | cm[i][1], "capture irq");
        end
        // timer written in event mode so no count tick can swallow the write
        wr(`PET_OFS_STATUS, 3);
        wr(`PET_OFS_IRQ_EN, 1);
        wr(`PET_OFS_CTRL, 0);
        wr(`PET_OFS_TIMER, 1);
        wr(`PET_OFS_CTRL, 4'he);
        repeat (40) @(posedge clk);
        bus(1'b0, `PET_OFS_TIMER, 0, t1);
        check(t1 >= 16'hfff0 && t1 <= 16'hffff, 1'b1, "wrap to all ones");
        rd_chk(`PET_OFS_CTRL, 4'hf, "underflow bit");
        check(irq, 1'b1, "underflow irq");
        wr(`PET_OFS_CTRL, 4'he);
        repeat (3) @(posedge clk);
        check(irq, 1'b0, "underflow irq cleared");
        $display("test capture done");

        // pwm with toggle, only enable a set
        wr(`PET_OFS_CTRL, 0);
        wr(`PET_OFS_RELOAD_A, 3);
        wr(`PET_OFS_RELOAD_B, 5);
        wr(`PET_OFS_TIMER, 2);
        wr(`PET_OFS_STATUS, 3);
        tog_q.delete();
        wr(`PET_OFS_CTRL, 4'ha);
        for (int k = 0; k < 4; k++) begin
            n = 0;
            while (tog_q.size() <= k && n < 200) begin
                @(posedge clk);
                n++;
            end
            repeat (3) @(posedge clk);
            check(irq, k % 2 == 0, "pwm irq gating");
            rd_chk(`PET_OFS_STATUS, (k % 2 == 0) ? 1 : 2, "pwm flag");
            wr(`PET_OFS_STATUS, 3);
        end
        check(tog_q[1] - tog_q[0], 40, "after a reload");
        check(tog_q[2] - tog_q[1], 60, "after b reload");
        check(tog_q[3] - tog_q[2], 40, "after a reload");
        check(pa_oe, 1'b1, "pwm drives pin");
        wr(`PET_OFS_CTRL, 4'h8);
        tog_q.delete();
        repeat (150) @(posedge clk);
        check(tog_q.size(), 0, "no toggle setting");
        rd_chk(`PET_OFS_STATUS, 3, "flags keep alternating");
        $display("test pwm done");
        tally_and_finish();
    end
endmodule : tb_pwm_event_capture_timer
